// [rtl/csp_can_signal_pack_unpack.sv]
// CAN signal packer/unpacker with AXI4-Lite configuration
`timescale 1ns/1ps
`default_nettype none
module csp_can_signal_pack_unpack #(
    parameter int MS_CYCLES = csp_pkg::MS_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] universal_input_first,
    input wire logic [2:0][15:0] universal_input_rest,
    input wire logic [7:0][15:0] logic_data,
    input wire logic [15:0] pid_output,
    input wire logic [5:0][15:0] const_user,
    input wire logic [15:0] motor_speed,
    input wire logic [15:0] motor_current,
    input wire logic [15:0] supply_voltage,
    input wire logic [15:0] proc_temperature,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [17:0] tx_pgn,
    output logic [63:0] tx_data,
    input wire logic rx_valid,
    input wire logic [17:0] rx_pgn,
    input wire logic [63:0] rx_data,
    output logic [3:0][15:0] rx_value,
    output logic [3:0] rx_digital,
    output logic [3:0] rx_lost,
    output logic [7:0] tx_threshold
);
    csp_pkg::csp_state_type st_reg, st_next;
    logic ms_tick;
    logic [3:0][15:0] uin;
    assign uin = {universal_input_rest, universal_input_first};

    function automatic logic in_rng(input logic [7:0] i, input logic [7:0] hi);
        return i >= csp_pkg::IDX_FIRST && i <= hi;
    endfunction

    // Selected source value, zero for an index out of range
    function automatic logic signed [15:0] src_val(input csp_pkg::csp_sel_type s);
        logic [7:0] k;
        k = s.idx - csp_pkg::IDX_FIRST;
        src_val = '0;
        case (s.stype)
            csp_pkg::SRC_RX: if (in_rng(s.idx, csp_pkg::IDX_RX_MAX)) src_val = st_reg.rval[k[1:0]];
            csp_pkg::SRC_UIN: if (in_rng(s.idx, csp_pkg::IDX_UIN_MAX)) src_val = uin[k[1:0]];
            csp_pkg::SRC_LOGIC: if (in_rng(s.idx, csp_pkg::IDX_LOGIC_MAX)) src_val = logic_data[k[2:0]];
            csp_pkg::SRC_PID: if (s.idx == csp_pkg::IDX_FIRST) src_val = pid_output;
            csp_pkg::SRC_CONST: begin
                if (s.idx == csp_pkg::IDX_TRUE) begin
                    src_val = 16'h0001;
                end else if (s.idx >= csp_pkg::IDX_USER0 && s.idx <= csp_pkg::IDX_CONST_MAX) begin
                    k = s.idx - csp_pkg::IDX_USER0;
                    src_val = const_user[k[2:0]];
                end
            end
            csp_pkg::SRC_RPM: src_val = motor_speed;
            csp_pkg::SRC_CURR: src_val = motor_current;
            csp_pkg::SRC_SUPPLY: src_val = supply_voltage;
            csp_pkg::SRC_TEMP: src_val = proc_temperature;
            csp_pkg::SRC_RXTO: src_val = {15'h0000, |st_reg.rlost};
            default: src_val = '0;
        endcase
    endfunction

    // Threshold compare for measured sources; threshold is index times RPM_STEP, MA_STEP, or 1 for supply and temperature
    function automatic logic src_thr(input csp_pkg::csp_sel_type s);
        logic [31:0] lvl;
        lvl = 32'(s.idx);
        case (s.stype)
            csp_pkg::SRC_RPM: src_thr = 32'(motor_speed) >= lvl * 32'(csp_pkg::RPM_STEP);
            csp_pkg::SRC_CURR: src_thr = 32'(motor_current) >= lvl * 32'(csp_pkg::MA_STEP);
            csp_pkg::SRC_SUPPLY: src_thr = 32'(supply_voltage) >= lvl;
            csp_pkg::SRC_TEMP: src_thr = 32'(proc_temperature) >= lvl;
            default: src_thr = 1'b0;
        endcase
    endfunction

    function automatic logic [63:0] fmask(input logic [5:0] size);
        return (64'h1 << size) - 64'h1;
    endfunction

    // Payload of one message: offset, scale, mask and place each signal
    function automatic logic [63:0] pack(input csp_pkg::csp_sel_type [3:0] sel,
                                         input csp_pkg::csp_scl_type [3:0] scl);
        logic signed [33:0] v;
        logic [63:0] f;
        pack = '0;
        for (int s = 0; s < csp_pkg::N_SIG; s++) begin
            v = (34'(src_val(sel[s])) - 34'(scl[s].off)) * $signed({18'h00000, scl[s].res});
            f = 64'($signed(v >>> csp_pkg::RES_FRAC)) & fmask(sel[s].size);
            if (sel[s].stype != csp_pkg::SRC_NONE) begin
                pack = pack | (f << (sel[s].byte_i * csp_pkg::BYTE_BITS + sel[s].bit_i));
            end
        end
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] b);
        for (int i = 0; i < 4; i++) begin
            wmerge[i*8 +: 8] = b[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        end
    endfunction

    // Read decode: bit 32 flags a mapped address
    function automatic logic [32:0] rd(input logic [11:0] a);
        rd = {1'b0, 32'h00000000};
        for (int m = 0; m < csp_pkg::N_TX; m++) begin
            if (a == csp_pkg::TX_BASE + 12'(m) * csp_pkg::TX_STRIDE + csp_pkg::TX_PGN)
                rd = {1'b1, 14'h0000, st_reg.tpgn[m]};
            if (a == csp_pkg::TX_BASE + 12'(m) * csp_pkg::TX_STRIDE + csp_pkg::TX_RATE)
                rd = {1'b1, 16'h0000, st_reg.trate[m]};
            for (int s = 0; s < csp_pkg::N_SIG; s++) begin
                if (a == csp_pkg::TX_BASE + 12'(m) * csp_pkg::TX_STRIDE + csp_pkg::TX_SEL
                        + 12'(s) * csp_pkg::SIG_STRIDE)
                    rd = {1'b1, 8'h00, st_reg.tsel[m*csp_pkg::N_SIG+s][23:0]};
                if (a == csp_pkg::TX_BASE + 12'(m) * csp_pkg::TX_STRIDE + csp_pkg::TX_SCL
                        + 12'(s) * csp_pkg::SIG_STRIDE)
                    rd = {1'b1, st_reg.tscl[m*csp_pkg::N_SIG+s]};
            end
        end
        for (int n = 0; n < csp_pkg::N_RX; n++) begin
            if (a == csp_pkg::RX_BASE + 12'(n) * csp_pkg::RX_STRIDE + csp_pkg::RX_CTRL)
                rd = {1'b1, st_reg.rctl[n]};
            if (a == csp_pkg::RX_BASE + 12'(n) * csp_pkg::RX_STRIDE + csp_pkg::RX_PGN)
                rd = {1'b1, 14'h0000, st_reg.rpgn[n]};
            if (a == csp_pkg::RX_BASE + 12'(n) * csp_pkg::RX_STRIDE + csp_pkg::RX_FLD)
                rd = {1'b1, st_reg.rfld[n]};
            if (a == csp_pkg::RX_BASE + 12'(n) * csp_pkg::RX_STRIDE + csp_pkg::RX_SCL)
                rd = {1'b1, st_reg.rscl[n]};
            if (a == csp_pkg::RX_BASE + 12'(n) * csp_pkg::RX_STRIDE + csp_pkg::RX_LIM)
                rd = {1'b1, st_reg.rlim[n]};
        end
        if (a == csp_pkg::STATUS)
            rd = {1'b1, 20'h00000, st_reg.rdig, st_reg.rlost, st_reg.tpend, st_reg.tvalid,
                  st_reg.hold_done};
    endfunction

    assign ms_tick = st_reg.ms_cnt == 32'(MS_CYCLES - 1);

    always_comb begin
        logic shared;
        logic [32:0] r;
        logic [63:0] raw;
        logic signed [49:0] eng;
        logic signed [15:0] lo;
        logic signed [15:0] hi;
        shared = 1'b0;
        r = '0;
        raw = '0;
        eng = '0;
        lo = '0;
        hi = '0;
        st_next = st_reg;
        st_next.ms_cnt = ms_tick ? 32'h00000000 : st_reg.ms_cnt + 32'h00000001;
        if (ms_tick && !st_reg.hold_done) begin
            st_next.hold_cnt = st_reg.hold_cnt + 16'h0001;
            st_next.hold_done = st_reg.hold_cnt + 16'h0001 >= csp_pkg::HOLDOFF_MS;
        end
        // Transmit scheduling
        shared = st_reg.tpgn[1] == st_reg.tpgn[0];
        if (st_reg.tvalid && tx_ready) st_next.tvalid = 1'b0;
        if (!st_reg.tvalid) begin
            if (st_reg.tpend[0]) begin
                st_next.tpend[0] = 1'b0;
                st_next.tvalid = 1'b1;
                st_next.tx_pgn = st_reg.tpgn[0];
                st_next.tx_data = pack(st_reg.tsel[3:0], st_reg.tscl[3:0]) |
                    (shared ? pack(st_reg.tsel[7:4], st_reg.tscl[7:4]) : 64'h0);
            end else if (st_reg.tpend[1]) begin
                st_next.tpend[1] = 1'b0;
                st_next.tvalid = 1'b1;
                st_next.tx_pgn = st_reg.tpgn[1];
                st_next.tx_data = pack(st_reg.tsel[7:4], st_reg.tscl[7:4]);
            end
        end
        // Timers after the frame build, so a new period wins over taking the old one
        for (int m = 0; m < csp_pkg::N_TX; m++) begin
            if (!st_reg.hold_done || st_reg.trate[m] == 16'h0000 || (m != 0 && shared)) begin
                st_next.tcnt[m] = '0;
            end else if (ms_tick) begin
                if (st_reg.tcnt[m] + 16'h0001 >= st_reg.trate[m]) begin
                    st_next.tcnt[m] = '0;
                    st_next.tpend[m] = 1'b1;
                end else begin
                    st_next.tcnt[m] = st_reg.tcnt[m] + 16'h0001;
                end
            end
        end
        for (int i = 0; i < csp_pkg::N_TX * csp_pkg::N_SIG; i++) begin
            st_next.thr[i] = src_thr(st_reg.tsel[i]);
        end
        // Receive supervision and extraction
        for (int n = 0; n < csp_pkg::N_RX; n++) begin
            if (!st_reg.rctl[n].en) begin
                st_next.rcnt[n] = '0;
                st_next.rlost[n] = 1'b0;
            end else if (rx_valid && rx_pgn == st_reg.rpgn[n]) begin
                st_next.rcnt[n] = '0;
                st_next.rlost[n] = 1'b0;
                raw = (rx_data >> (st_reg.rfld[n].byte_i * csp_pkg::BYTE_BITS
                       + st_reg.rfld[n].bit_i)) & fmask(st_reg.rfld[n].size);
                eng = ($signed({18'h00000, raw[31:0]}) * $signed({34'h0, st_reg.rscl[n].res}))
                      >>> csp_pkg::RES_FRAC;
                eng = eng + 50'(st_reg.rscl[n].off);
                lo = st_reg.rlim[n].min;
                hi = st_reg.rlim[n].max;
                st_next.rval[n] = eng < 50'(lo) ? lo : (eng > 50'(hi) ? hi : eng[15:0]);
                if (eng >= 50'(hi)) st_next.rdig[n] = 1'b1;
                else if (eng <= 50'(lo)) st_next.rdig[n] = 1'b0;
            end else if (st_reg.rctl[n].timeout == 16'h0000) begin
                st_next.rcnt[n] = '0;
            end else if (ms_tick && st_reg.rcnt[n] != 16'hFFFF) begin
                st_next.rcnt[n] = st_reg.rcnt[n] + 16'h0001;
                if (st_reg.rcnt[n] + 16'h0001 >= st_reg.rctl[n].timeout)
                    st_next.rlost[n] = 1'b1;
            end
        end
        // AXI4-Lite write: address and data taken in either order
        if (s_axi_awvalid && !st_reg.awv && !st_reg.bvalid) begin
            st_next.awv = 1'b1;
            st_next.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.wv && !st_reg.bvalid) begin
            st_next.wv = 1'b1;
            st_next.wd = s_axi_wdata;
            st_next.ws = s_axi_wstrb;
        end
        if (st_reg.bvalid && s_axi_bready) st_next.bvalid = 1'b0;
        if (st_reg.awv && st_reg.wv) begin
            r = rd(st_reg.awa);
            st_next.awv = 1'b0;
            st_next.wv = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = r[32] ? csp_pkg::RESP_OKAY : csp_pkg::RESP_SLVERR;
            r[31:0] = wmerge(r[31:0], st_reg.wd, st_reg.ws);
            for (int m = 0; m < csp_pkg::N_TX; m++) begin
                if (st_reg.awa == csp_pkg::TX_BASE + 12'(m) * csp_pkg::TX_STRIDE + csp_pkg::TX_PGN)
                    st_next.tpgn[m] = r[17:0];
                if (st_reg.awa == csp_pkg::TX_BASE + 12'(m) * csp_pkg::TX_STRIDE + csp_pkg::TX_RATE)
                    st_next.trate[m] = r[15:0];
                for (int s = 0; s < csp_pkg::N_SIG; s++) begin
                    if (st_reg.awa == csp_pkg::TX_BASE + 12'(m) * csp_pkg::TX_STRIDE
                            + csp_pkg::TX_SEL + 12'(s) * csp_pkg::SIG_STRIDE)
                        st_next.tsel[m*csp_pkg::N_SIG+s] = {8'h00, r[23:0]};
                    if (st_reg.awa == csp_pkg::TX_BASE + 12'(m) * csp_pkg::TX_STRIDE
                            + csp_pkg::TX_SCL + 12'(s) * csp_pkg::SIG_STRIDE)
                        st_next.tscl[m*csp_pkg::N_SIG+s] = r[31:0];
                end
            end
            for (int n = 0; n < csp_pkg::N_RX; n++) begin
                if (st_reg.awa == csp_pkg::RX_BASE + 12'(n) * csp_pkg::RX_STRIDE + csp_pkg::RX_CTRL)
                    st_next.rctl[n] = {r[31:16], 15'h0000, r[0]};
                if (st_reg.awa == csp_pkg::RX_BASE + 12'(n) * csp_pkg::RX_STRIDE + csp_pkg::RX_PGN)
                    st_next.rpgn[n] = r[17:0];
                if (st_reg.awa == csp_pkg::RX_BASE + 12'(n) * csp_pkg::RX_STRIDE + csp_pkg::RX_FLD)
                    st_next.rfld[n] = {20'h00000, r[11:0]};
                if (st_reg.awa == csp_pkg::RX_BASE + 12'(n) * csp_pkg::RX_STRIDE + csp_pkg::RX_SCL)
                    st_next.rscl[n] = r[31:0];
                if (st_reg.awa == csp_pkg::RX_BASE + 12'(n) * csp_pkg::RX_STRIDE + csp_pkg::RX_LIM)
                    st_next.rlim[n] = r[31:0];
            end
        end
        // AXI4-Lite read
        if (st_reg.rvalid && s_axi_rready) st_next.rvalid = 1'b0;
        if (s_axi_arvalid && !st_reg.rvalid) begin
            r = rd(s_axi_araddr);
            st_next.rvalid = 1'b1;
            st_next.rdata = r[31:0];
            st_next.rresp = r[32] ? csp_pkg::RESP_OKAY : csp_pkg::RESP_SLVERR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg <= '0;
            st_reg.tpgn[0] <= csp_pkg::DEF_PGN;
            st_reg.tpgn[1] <= csp_pkg::DEF_PGN + 18'h00001;
            st_reg.tscl <= {8{csp_pkg::RES_ONE, 16'h0000}};
            st_reg.rscl <= {4{csp_pkg::RES_ONE, 16'h0000}};
            st_reg.rlim <= {4{16'h7FFF, 16'h8000}};
            st_reg.trate[0] <= csp_pkg::DEF_RATE;
            st_reg.tsel[0] <= {8'h00, 3'h0, 3'h0, csp_pkg::DEF_SIZE, csp_pkg::IDX_FIRST,
                               csp_pkg::SRC_UIN};
            st_reg.tsel[1] <= {8'h00, 3'h0, 3'h2, csp_pkg::DEF_SIZE, csp_pkg::IDX_FIRST,
                               csp_pkg::SRC_RPM};
            st_reg.tsel[2] <= {8'h00, 3'h0, 3'h4, csp_pkg::DEF_SIZE, csp_pkg::IDX_FIRST,
                               csp_pkg::SRC_CURR};
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = !st_reg.awv && !st_reg.bvalid;
    assign s_axi_wready = !st_reg.wv && !st_reg.bvalid;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = !st_reg.rvalid;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign tx_valid = st_reg.tvalid;
    assign tx_pgn = st_reg.tx_pgn;
    assign tx_data = st_reg.tx_data;
    assign rx_value = st_reg.rval;
    assign rx_digital = st_reg.rdig;
    assign rx_lost = st_reg.rlost;
    assign tx_threshold = st_reg.thr;
endmodule
`default_nettype wire

// [rtl/csp_pkg.sv]
// Constants, field layouts and state of the CAN signal packer and unpacker
`default_nettype none
package csp_pkg;
    localparam int N_TX = 2;
    localparam int N_SIG = 4;
    localparam int N_RX = 4;
    localparam int CLK_NS = 4;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_NS;
    localparam int HOLDOFF_S = 2;
    localparam logic [15:0] HOLDOFF_MS = 16'(HOLDOFF_S * 1000);
    localparam int BYTE_BITS = 8;
    localparam int RES_FRAC = 8;
    localparam logic [15:0] RES_ONE = 16'h0100;
    localparam logic [17:0] DEF_PGN = 18'h0FF00;
    localparam logic [15:0] DEF_RATE = 16'h0064;
    localparam logic [5:0] DEF_SIZE = 6'h10;
    localparam logic [7:0] IDX_FIRST = 8'h01;
    localparam logic [7:0] IDX_RX_MAX = 8'h04;
    localparam logic [7:0] IDX_UIN_MAX = 8'h04;
    localparam logic [7:0] IDX_LOGIC_MAX = 8'h08;
    localparam logic [7:0] IDX_CONST_MAX = 8'h08;
    localparam logic [7:0] IDX_FALSE = 8'h01;
    localparam logic [7:0] IDX_TRUE = 8'h02;
    localparam logic [7:0] IDX_USER0 = 8'h03;
    localparam int RPM_STEP = 100;
    localparam int MA_STEP = 50;
    localparam logic [11:0] TX_BASE = 12'h000;
    localparam logic [11:0] TX_STRIDE = 12'h040;
    localparam logic [11:0] TX_PGN = 12'h000;
    localparam logic [11:0] TX_RATE = 12'h004;
    localparam logic [11:0] TX_SEL = 12'h008;
    localparam logic [11:0] TX_SCL = 12'h00C;
    localparam logic [11:0] SIG_STRIDE = 12'h008;
    localparam logic [11:0] RX_BASE = 12'h100;
    localparam logic [11:0] RX_STRIDE = 12'h020;
    localparam logic [11:0] RX_CTRL = 12'h000;
    localparam logic [11:0] RX_PGN = 12'h004;
    localparam logic [11:0] RX_FLD = 12'h008;
    localparam logic [11:0] RX_SCL = 12'h00C;
    localparam logic [11:0] RX_LIM = 12'h010;
    localparam logic [11:0] STATUS = 12'h200;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [3:0] {
        SRC_NONE, SRC_RX, SRC_UIN, SRC_LOGIC, SRC_PID, SRC_CONST,
        SRC_RPM, SRC_CURR, SRC_SUPPLY, SRC_TEMP, SRC_RXTO
    } csp_src_type;
    typedef struct packed {
        logic [1:0] rsv; logic [5:0] bit_i_hi; logic [2:0] bit_i;
        logic [2:0] byte_i; logic [5:0] size; logic [7:0] idx; csp_src_type stype;
    } csp_sel_type;
    typedef struct packed {logic [15:0] res; logic signed [15:0] off;} csp_scl_type;
    typedef struct packed {logic signed [15:0] max; logic signed [15:0] min;} csp_lim_type;
    typedef struct packed {logic [15:0] timeout; logic [14:0] rsv; logic en;} csp_rctl_type;
    typedef struct packed {
        logic [19:0] rsv; logic [2:0] bit_i; logic [2:0] byte_i; logic [5:0] size;
    } csp_fld_type;
    typedef struct packed {
        logic [N_TX-1:0][17:0] tpgn;
        logic [N_TX-1:0][15:0] trate;
        csp_sel_type [N_TX*N_SIG-1:0] tsel;
        csp_scl_type [N_TX*N_SIG-1:0] tscl;
        csp_rctl_type [N_RX-1:0] rctl;
        logic [N_RX-1:0][17:0] rpgn;
        csp_fld_type [N_RX-1:0] rfld;
        csp_scl_type [N_RX-1:0] rscl;
        csp_lim_type [N_RX-1:0] rlim;
        logic [31:0] ms_cnt;
        logic [15:0] hold_cnt;
        logic hold_done;
        logic [N_TX-1:0][15:0] tcnt;
        logic [N_TX-1:0] tpend;
        logic tvalid;
        logic [17:0] tx_pgn;
        logic [63:0] tx_data;
        logic [N_RX-1:0][15:0] rcnt;
        logic [N_RX-1:0] rlost;
        logic [N_RX-1:0][15:0] rval;
        logic [N_RX-1:0] rdig;
        logic [N_TX*N_SIG-1:0] thr;
        logic awv; logic [11:0] awa; logic wv; logic [31:0] wd; logic [3:0] ws;
        logic bvalid; logic [1:0] bresp; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    } csp_state_type;
endpackage
`default_nettype wire

// [testbench/csp_checker.sv]
// Port assertions for the CAN signal packer and unpacker
`timescale 1ns/1ps
`default_nettype none
module csp_checker #(
    parameter int MS_CYCLES = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [17:0] tx_pgn,
    input wire logic [63:0] tx_data
);
    localparam int HOLD = 2000 * MS_CYCLES;
    logic [31:0] up_cnt;
    // Cycles since reset release, saturating at the holdoff length
    always_ff @(posedge aclk) begin
        if (!aresetn) up_cnt <= 32'h0;
        else if (up_cnt < HOLD) up_cnt <= up_cnt + 32'h1;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_tx_stable: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
        && $stable(tx_pgn)) else $error("frame changed while waiting");
    a_tx_release: assert property ($fell(tx_valid) |-> $past(tx_ready))
        else $error("frame dropped untaken");
    a_holdoff_gate: assert property (tx_valid |-> up_cnt >= HOLD)
        else $error("frame before holdoff");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_r_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during answer");
endmodule
bind csp_can_signal_pack_unpack csp_checker #(.MS_CYCLES(MS_CYCLES)) chk_u (.*);
`default_nettype wire

// [testbench/csp_can_node.sv]
// Far-side CAN node: takes frames every other cycle, sends frames on request
`timescale 1ns/1ps
`default_nettype none
module csp_can_node (
    input wire logic aclk,
    output logic tx_ready,
    output logic rx_valid,
    output logic [17:0] rx_pgn,
    output logic [63:0] rx_data
);
    initial tx_ready = 1'b0;
    initial rx_valid = 1'b0;
    initial rx_pgn = 18'h00000;
    initial rx_data = 64'h0;
    always @(posedge aclk) tx_ready <= !tx_ready;
    task automatic send(input logic [17:0] p, input logic [63:0] d);
        rx_valid <= 1'b1;
        rx_pgn <= p;
        rx_data <= d;
        @(posedge aclk);
        rx_valid <= 1'b0;
        rx_pgn <= ~p;
        rx_data <= ~d;
    endtask
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the CAN signal packer and unpacker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] universal_input_first = 16'h1234, motor_speed = 16'h0BB8;
    logic [15:0] motor_current = 16'h0064, pid_output = 16'h0007;
    logic [15:0] supply_voltage = 16'h000C, proc_temperature = 16'h0019;
    logic [2:0][15:0] universal_input_rest = '0;
    logic [7:0][15:0] logic_data = '0;
    logic [5:0][15:0] const_user = '0;
    logic tx_valid, tx_ready, rx_valid;
    logic [17:0] tx_pgn, rx_pgn;
    logic [63:0] tx_data, rx_data;
    logic [3:0][15:0] rx_value;
    logic [3:0] rx_digital, rx_lost;
    logic [7:0] tx_threshold;
    int miscompares = 0, n_compared = 0, cycles = 0;
    csp_can_signal_pack_unpack #(.MS_CYCLES(2)) dut_u (.*);
    csp_can_node p_u (.*);
    initial forever #2 aclk = ~aclk;
    task automatic finish_test;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 12000) begin
            miscompares++;
            finish_test();
        end
    end
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        // Each channel is released at the edge that takes it
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        check("bresp", 64'(er), 64'(s_axi_bresp));
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        check("rdata", 64'(ed), 64'(s_axi_rdata));
        check("rresp", 64'(er), 64'(s_axi_rresp));
    endtask
    task automatic t_regs;
        rd(12'h000, 32'h0000FF00, csp_pkg::RESP_OKAY);
        rd(12'h040, 32'h0000FF01, csp_pkg::RESP_OKAY);
        rd(12'h200, 32'h00000000, csp_pkg::RESP_OKAY);
        rd(12'hFFC, 32'h00000000, csp_pkg::RESP_SLVERR);
        wr(12'hFFC, 32'hFFFFFFFF, csp_pkg::RESP_SLVERR);
    endtask
    task automatic t_rx;
        wr(12'h104, 32'h0000FF10, csp_pkg::RESP_OKAY);
        wr(12'h108, 32'h00000050, csp_pkg::RESP_OKAY);
        wr(12'h110, 32'h01000000, csp_pkg::RESP_OKAY);
        wr(12'h100, 32'h00030001, csp_pkg::RESP_OKAY);
        wr(12'h124, 32'h0000FF10, csp_pkg::RESP_OKAY);
        wr(12'h128, 32'h00000050, csp_pkg::RESP_OKAY);
        wr(12'h12C, 32'h02000005, csp_pkg::RESP_OKAY);
        wr(12'h120, 32'h00000001, csp_pkg::RESP_OKAY);
        p_u.send(18'h0FF10, 64'h0000000000030000);
        @(posedge aclk);
        check("clamped value", 64'h0100, 64'(rx_value[0]));
        check("scaled value", 64'h0605, 64'(rx_value[1]));
        check("idle value", 64'h0, 64'(rx_value[2]));
        check("digital", 64'h1, 64'(rx_digital[0]));
        check("lost early", 64'h0, 64'(rx_lost));
        repeat (20) @(posedge aclk);
        check("lost", 64'h1, 64'(rx_lost));
    endtask
    task automatic t_tx;
        wr(12'h00C, 32'h02000004, csp_pkg::RESP_OKAY);
        wr(12'h040, 32'h0000FF00, csp_pkg::RESP_OKAY);
        wr(12'h048, 32'h00188025, csp_pkg::RESP_OKAY);
        do @(posedge aclk); while (!(tx_valid && tx_ready));
        check("holdoff", 64'h1, 64'(cycles >= 4002));
        check("pgn", 64'h0FF00, 64'(tx_pgn));
        check("payload", 64'h0001_0064_0BB8_2460, tx_data);
        check("thresholds", 64'h3, 64'(tx_threshold[2:1]));
        motor_current <= 16'h0031;
        repeat (4) @(posedge aclk);
        check("current below", 64'h0, 64'(tx_threshold[2]));
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_rx();
        t_tx();
        finish_test();
    end
endmodule
`default_nettype wire
